// ### rtl/gp_timer_pkg.sv
package gp_timer_pkg;
	// ==========================================================
	// Configuration and mode encodings
	localparam logic [2:0]  CFG_32BIT     = 3'h0;    // Plain timer configuration
	localparam logic [2:0]  CFG_RTC       = 3'h1;    // Real-time clock configuration
	localparam logic [2:0]  CFG_16BIT     = 3'h4;    // Split half-timer configuration
	localparam logic [1:0]  TMR_ONE_SHOT  = 2'h1;    // Stop after time-out
	localparam logic [1:0]  TMR_PERIODIC  = 2'h2;    // Also the PWM mode code
	localparam logic [1:0]  TMR_CAPTURE   = 2'h3;    // Either input capture mode
	localparam logic [1:0]  EVT_RISE      = 2'h0;    // Rising edges
	localparam logic [1:0]  EVT_FALL      = 2'h1;    // Falling edges
	localparam logic [1:0]  EVT_BOTH      = 2'h3;    // Both edges, counting only
	// ==========================================================
	// Status flag positions
	localparam int          FLG_TIMEOUT   = 0;       // Time-out flag
	localparam int          FLG_MATCH     = 1;       // Edge-count match flag
	localparam int          FLG_EVENT     = 2;       // Edge-time capture flag
	localparam int          FLG_RTC       = 3;       // RTC match flag
	// ==========================================================
	// Reset values and counts
	localparam logic [15:0] LOAD_RST      = 16'hFFFF; // Load, match and counter
	localparam logic [15:0] RTC_START     = 16'h0001; // First RTC count
	localparam logic [14:0] RTC_DIV_LAST  = 15'h7FFF; // Last divider count, one below slow-clock edges per second
	// ==========================================================
	// Decoded operating mode, one-hot
	typedef enum logic [5:0] {
		MODE_OFF   = 6'h01,
		MODE_TIMER = 6'h02,
		MODE_RTC   = 6'h04,
		MODE_ECNT  = 6'h08,
		MODE_ETIME = 6'h10,
		MODE_PWM   = 6'h20
	} mode_t;
endpackage : gp_timer_pkg

// ### rtl/gp_timer.sv
`timescale 1ns/1ps
module gp_timer import gp_timer_pkg::*; (
	input  wire logic        clock_i,               // System clock, 200 MHz
	input  wire logic        nrst_i,                // Async reset, active low
	input  wire logic        ce_i,                  // Clock enable, freezes all
	input  wire logic        capture_pin_i,         // Capture/compare pin in
	input  wire logic [2:0]  global_config_i,       // Global configuration
	input  wire logic [1:0]  timer_mode_field_i,    // Timer mode field
	input  wire logic        capture_mode_select_i, // 0 count, 1 time
	input  wire logic        alternate_mode_select_i, // 1 selects PWM
	input  wire logic [1:0]  edge_event_field_i,    // Edge type select
	input  wire logic        pwm_output_invert_i,   // Invert PWM output
	input  wire logic        run_enable_set_i,      // Pulse, start timer
	input  wire logic        run_enable_clear_i,    // Pulse, stop timer
	input  wire logic [15:0] interval_load_i,       // Interval load data
	input  wire logic        interval_load_we_i,    // Pulse, write load
	input  wire logic [15:0] match_value_i,         // Match data
	input  wire logic        match_value_we_i,      // Pulse, write match
	input  wire logic [7:0]  prescale_i,            // Prescale, 16-bit timer mode only
	input  wire logic [3:0]  interrupt_mask_i,      // Mask per flag
	input  wire logic [3:0]  interrupt_clear_i,     // Pulse, clear per flag
	output logic             run_enable_o,          // Run-enable state
	output logic [15:0]      timer_value_o,         // Count or captured value
	output logic [3:0]       raw_status_o,          // Raw status flags
	output logic [3:0]       masked_status_o,       // Masked status flags
	output logic             irq_o,                 // Controller interrupt
	output logic             pwm_o                  // PWM output pin
);
	// ==========================================================
	// State
	logic [15:0] interval_load_reg;  // Reload value
	logic [15:0] match_value_reg;    // Match value
	logic [15:0] count_reg;          // Main counter
	logic [15:0] count_next;
	logic [7:0]  pre_reg;            // Prescale counter
	logic [7:0]  pre_next;
	logic [14:0] rtc_div_reg;        // Slow clock divider
	logic [14:0] rtc_div_next;
	logic [15:0] timer_value_reg;    // Captured count
	logic        run_reg;            // Run enable
	logic        run_next;
	logic [3:0]  raw_reg;            // Sticky raw flags
	logic [3:0]  flag_set;           // Hardware flag events
	logic        pwm_level_reg;      // Uninverted PWM level
	logic        pwm_level_next;
	logic        pwm_out_reg;        // Registered pin value
	logic        pin_s1_reg;         // Synchroniser stage one
	logic        pin_s2_reg;         // Synchroniser stage two
	logic        pin_d_reg;          // Delayed copy for edges
	mode_t       mode;
	// ==========================================================
	// Mode decode
	wire cfg16    = (global_config_i == CFG_16BIT);
	wire tmr_cap  = (timer_mode_field_i == TMR_CAPTURE);
	wire tmr_cnt  = (timer_mode_field_i == TMR_ONE_SHOT) ||
	                (timer_mode_field_i == TMR_PERIODIC);
	wire is_pwm   = cfg16 && alternate_mode_select_i && !capture_mode_select_i &&
	                (timer_mode_field_i == TMR_PERIODIC);
	wire is_ecnt  = cfg16 && tmr_cap && !capture_mode_select_i;
	wire is_etime = cfg16 && tmr_cap && capture_mode_select_i;
	wire is_timer = (cfg16 || global_config_i == CFG_32BIT) &&
	                !alternate_mode_select_i && tmr_cnt;
	assign mode = is_pwm   ? MODE_PWM   :
	              is_ecnt  ? MODE_ECNT  :
	              is_etime ? MODE_ETIME :
	              (global_config_i == CFG_RTC) ? MODE_RTC :
	              is_timer ? MODE_TIMER : MODE_OFF;
	// ==========================================================
	// Edge qualification
	wire rise     = pin_s2_reg && !pin_d_reg;
	wire fall     = !pin_s2_reg && pin_d_reg;
	// Counting may take both edges
	wire cnt_edge = (edge_event_field_i == EVT_BOTH) ? (rise || fall) :
	                (edge_event_field_i == EVT_FALL) ? fall : rise;
	// Timing cannot take both; that code falls back to rising
	wire tim_edge = (edge_event_field_i == EVT_FALL) ? fall : rise;
	wire [15:0] cnt_minus = count_reg - 16'h0001;
	wire zero     = (count_reg == 16'h0000);
	// Prescaler only ever applies in timer mode of the split 16-bit configuration
	wire pre_use  = cfg16 && (pre_reg != 8'h00);
	// ==========================================================
	// Counter, prescaler and flag next values
	always_comb begin
		count_next     = count_reg;
		pre_next       = pre_reg;
		rtc_div_next   = rtc_div_reg;
		run_next       = run_reg;
		flag_set       = 4'h0;
		pwm_level_next = pwm_level_reg;
		case (mode)
			MODE_TIMER: begin
				if (run_reg) begin
					if (pre_use) begin
						pre_next = pre_reg - 8'h01;
					end else if (zero) begin
						count_next = interval_load_reg;
						pre_next   = cfg16 ? prescale_i : 8'h00;
						flag_set[FLG_TIMEOUT] = 1'b1;
						if (timer_mode_field_i == TMR_ONE_SHOT) begin
							run_next = 1'b0;
						end
					end else begin
						count_next = cnt_minus;
						pre_next   = cfg16 ? prescale_i : 8'h00;
					end
				end
			end
			MODE_RTC: begin
				// Slow clock divided to one tick a second
				if (run_reg && rise) begin
					rtc_div_next = rtc_div_reg + 15'h0001;
					if (rtc_div_reg == RTC_DIV_LAST) begin
						if (count_reg == match_value_reg) begin
							count_next = 16'h0000;
							flag_set[FLG_RTC] = 1'b1;
						end else begin
							count_next = count_reg + 16'h0001;
						end
					end
				end
			end
			MODE_ECNT: begin
				// Edges after the match wait for software
				if (run_reg && cnt_edge) begin
					if (cnt_minus == match_value_reg) begin
						count_next = interval_load_reg;
						run_next   = 1'b0;
						flag_set[FLG_MATCH] = 1'b1;
					end else begin
						count_next = cnt_minus;
					end
				end
			end
			MODE_ETIME: begin
				if (run_reg) begin
					count_next = zero ? interval_load_reg : cnt_minus;
					flag_set[FLG_EVENT] = tim_edge;
				end
			end
			MODE_PWM: begin
				// No flag is ever raised here
				if (run_reg) begin
					count_next = zero ? interval_load_reg : cnt_minus;
					if (count_reg == interval_load_reg) begin
						pwm_level_next = 1'b1;
					end else if (count_reg == match_value_reg) begin
						pwm_level_next = 1'b0;
					end
				end
			end
			default: begin
				count_next = count_reg;
			end
		endcase
		// Load write takes effect on the next cycle
		if (interval_load_we_i) begin
			count_next = interval_load_i;
		end
		// RTC always starts from one on enable
		if (run_enable_set_i && mode == MODE_RTC) begin
			count_next = RTC_START;
		end
		if (run_enable_clear_i) begin
			run_next = 1'b0;
		end
		// Software start wins over a hardware stop
		if (run_enable_set_i) begin
			run_next = 1'b1;
		end
	end
	// ==========================================================
	// Pin synchroniser; first stage feeds only the second
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_s1_reg <= 1'b0;
			pin_s2_reg <= 1'b0;
			pin_d_reg  <= 1'b0;
		end else if (ce_i) begin
			pin_s1_reg <= capture_pin_i;
			pin_s2_reg <= pin_s1_reg;
			pin_d_reg  <= pin_s2_reg;
		end
	end
	// ==========================================================
	// Configuration registers
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			interval_load_reg <= LOAD_RST;
			match_value_reg   <= LOAD_RST;
		end else if (ce_i) begin
			if (interval_load_we_i) begin
				interval_load_reg <= interval_load_i;
			end
			if (match_value_we_i) begin
				match_value_reg <= match_value_i;
			end
		end
	end
	// ==========================================================
	// Counter state
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			count_reg     <= LOAD_RST;
			pre_reg       <= 8'h00;
			rtc_div_reg   <= 15'h0000;
			run_reg       <= 1'b0;
			pwm_level_reg <= 1'b0;
			pwm_out_reg   <= 1'b0;
		end else if (ce_i) begin
			count_reg     <= count_next;
			pre_reg       <= pre_next;
			rtc_div_reg   <= rtc_div_next;
			run_reg       <= run_next;
			pwm_level_reg <= pwm_level_next;
			pwm_out_reg   <= pwm_level_next ^ pwm_output_invert_i;
		end
	end
	// ==========================================================
	// Capture and sticky flags; a set beats a same-cycle clear
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			timer_value_reg <= LOAD_RST;
			raw_reg         <= 4'h0;
		end else if (ce_i) begin
			if (flag_set[FLG_EVENT]) begin
				timer_value_reg <= count_reg;
			end
			raw_reg <= (raw_reg & ~interrupt_clear_i) | flag_set;
		end
	end
	// ==========================================================
	// Outputs
	assign run_enable_o    = run_reg;
	assign timer_value_o   = (mode == MODE_ETIME) ? timer_value_reg : count_reg;
	assign raw_status_o    = raw_reg;
	assign masked_status_o = raw_reg & interrupt_mask_i;
	assign irq_o           = |(raw_reg & interrupt_mask_i);
	assign pwm_o           = pwm_out_reg;
	// ==========================================================
	// Checks
	wire quiet = ce_i && !interval_load_we_i && !run_enable_set_i && !run_enable_clear_i;
	AST_ECNT_DEC: assert property (@(posedge clock_i) disable iff (!nrst_i)
		quiet && mode == MODE_ECNT && run_reg && cnt_edge && cnt_minus != match_value_reg
		|=> count_reg == $past(count_reg) - 16'h0001 && run_enable_o)
		else $error("edge count did not decrement");
	AST_ECNT_STOP: assert property (@(posedge clock_i) disable iff (!nrst_i)
		quiet && mode == MODE_ECNT && run_reg && cnt_edge && cnt_minus == match_value_reg
		|=> !run_enable_o && raw_status_o[FLG_MATCH] && count_reg == interval_load_reg)
		else $error("edge count match did not stop and reload");
	AST_ECNT_IDLE: assert property (@(posedge clock_i) disable iff (!nrst_i)
		quiet && mode == MODE_ECNT && !run_reg |=> $stable(count_reg))
		else $error("stopped edge counter moved");
	AST_CAPTURE: assert property (@(posedge clock_i) disable iff (!nrst_i)
		quiet && mode == MODE_ETIME && run_reg && tim_edge
		|=> timer_value_reg == $past(count_reg) && raw_status_o[FLG_EVENT])
		else $error("edge time capture missed");
	AST_ETIME_WRAP: assert property (@(posedge clock_i) disable iff (!nrst_i)
		quiet && mode == MODE_ETIME && run_reg && zero
		|=> count_reg == interval_load_reg && run_enable_o)
		else $error("edge time did not reload at zero");
	AST_PWM_NOFLAG: assert property (@(posedge clock_i) disable iff (!nrst_i)
		ce_i && mode == MODE_PWM |=> (raw_status_o & ~$past(raw_status_o)) == 4'h0)
		else $error("flag raised in PWM mode");
	AST_PWM_RUN: assert property (@(posedge clock_i) disable iff (!nrst_i)
		quiet && mode == MODE_PWM && run_reg && !zero
		|=> count_reg == $past(count_reg) - 16'h0001)
		else $error("PWM counter did not step by one");
	AST_PWM_MATCH: assert property (@(posedge clock_i) disable iff (!nrst_i)
		quiet && mode == MODE_PWM && run_reg && count_reg == match_value_reg &&
		count_reg != interval_load_reg |=> pwm_o == $past(pwm_output_invert_i))
		else $error("PWM output not deasserted at match");
	AST_ONESHOT: assert property (@(posedge clock_i) disable iff (!nrst_i)
		quiet && mode == MODE_TIMER && timer_mode_field_i == TMR_ONE_SHOT && run_reg &&
		zero && !pre_use |=> !run_enable_o && raw_status_o[FLG_TIMEOUT])
		else $error("one-shot did not stop at time-out");
	AST_IRQ: assert property (@(posedge clock_i) disable iff (!nrst_i)
		irq_o == |masked_status_o && (masked_status_o & ~raw_status_o) == 4'h0)
		else $error("interrupt does not follow masked flags");
endmodule : gp_timer

// ### testbench/gp_edge_source.sv
`timescale 1ns/1ps
// ==========================================================
// External edge source on the capture pin
module gp_edge_source #(
	parameter int HOLD = 4                // Cycles between toggles
) (
	input  wire logic       clock_i,      // System clock
	input  wire logic       nrst_i,       // Async reset, active low
	input  wire logic       start_i,      // Pulse, begin a burst
	input  wire logic [7:0] edges_i,      // Edges in the burst
	output logic            pin_o,        // Level on the capture pin
	output logic            busy_o        // Burst still running
);
	logic [7:0] left_reg;                 // Edges still to make
	logic [7:0] wait_reg;                 // Cycles until next edge
	// Each level is held HOLD cycles, with no lower bound enforced
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			left_reg <= 8'h00;
			wait_reg <= 8'h00;
			pin_o    <= 1'b0;
		end else if (start_i) begin
			left_reg <= edges_i;
			wait_reg <= 8'(HOLD - 1);
		end else if (left_reg != 8'h00) begin
			if (wait_reg == 8'h00) begin
				pin_o    <= ~pin_o;
				left_reg <= left_reg - 8'h01;
				wait_reg <= 8'(HOLD - 1);
			end else begin
				wait_reg <= wait_reg - 8'h01;
			end
		end
	end
	assign busy_o = (left_reg != 8'h00);
endmodule : gp_edge_source

// ### testbench/gp_timer_capture_pwm_modes_tb_top.sv
`timescale 1ns/1ps
module gp_timer_capture_pwm_modes_tb_top import gp_timer_pkg::*;;
	// ==========================================================
	// Stimulus and observed signals
	logic        clock_i = 1'b0;          // 200 MHz clock
	logic        nrst_i = 1'b0;           // Reset, active low
	logic        ce = 1'b0;               // Timer clock gate
	logic        cms = 1'b0, ams = 1'b0, inv = 1'b0;
	logic        rs = 1'b0, rc = 1'b0, lwe = 1'b0, mwe = 1'b0, go = 1'b0;
	logic [2:0]  cfg = 3'h0;
	logic [1:0]  mode = 2'h0, evt = 2'h0;
	logic [15:0] ld = 16'h0000, mt = 16'h0000;
	logic [7:0]  pre = 8'h00, src_n = 8'h00;
	logic [3:0]  msk = 4'h0, clr = 4'h0;
	logic        run, irq, pwm, pin, busy;
	logic [15:0] tv;
	logic [3:0]  raw, mskd;
	int          miscompares = 0;
	int          num_checks = 0;
	always #2.5 clock_i = ~clock_i;
	gp_timer dut_u (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce), .capture_pin_i(pin),
		.global_config_i(cfg), .timer_mode_field_i(mode), .capture_mode_select_i(cms),
		.alternate_mode_select_i(ams), .edge_event_field_i(evt), .pwm_output_invert_i(inv),
		.run_enable_set_i(rs), .run_enable_clear_i(rc), .interval_load_i(ld),
		.interval_load_we_i(lwe), .match_value_i(mt), .match_value_we_i(mwe),
		.prescale_i(pre), .interrupt_mask_i(msk), .interrupt_clear_i(clr),
		.run_enable_o(run), .timer_value_o(tv), .raw_status_o(raw),
		.masked_status_o(mskd), .irq_o(irq), .pwm_o(pwm));
	gp_edge_source #(.HOLD(4)) src_u (.clock_i(clock_i), .nrst_i(nrst_i), .start_i(go),
		.edges_i(src_n), .pin_o(pin), .busy_o(busy));
	// ==========================================================
	// Shared helpers
	task test_done;
		$display("checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : test_done
	task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : tick
	// Run is dropped before any change, so setup never races a live count
	task setup(input logic [2:0] c, input logic [1:0] m, input logic cm, input logic am,
		input logic [1:0] ev, input logic [7:0] p, input logic [3:0] mk);
		@(posedge clock_i) rc <= 1'b1;
		@(posedge clock_i) begin
			rc <= 1'b0;
			{cfg, mode, cms, ams, evt, pre, msk} <= {c, m, cm, am, ev, p, mk};
		end
		#1;
	endtask : setup
	task load(input logic [15:0] l, input logic [15:0] m);
		@(posedge clock_i) {ld, mt, lwe, mwe} <= {l, m, 2'b11};
		@(posedge clock_i) {lwe, mwe} <= 2'b00;
		@(posedge clock_i) rs <= 1'b1;
		@(posedge clock_i) rs <= 1'b0;
		#1;
	endtask : load
	task clear_flags(input logic [3:0] f);
		@(posedge clock_i) clr <= f;
		@(posedge clock_i) clr <= 4'h0;
		tick(1);
	endtask : clear_flags
	task src_start(input logic [7:0] n);
		@(posedge clock_i) {src_n, go} <= {n, 1'b1};
		@(posedge clock_i) go <= 1'b0;
		#1;
	endtask : src_start
	task edges(input logic [7:0] n);
		src_start(n);
		for (int i = 0; i < 400 && busy === 1'b1; i++) tick(1);
		if (busy !== 1'b0) begin
			miscompares++;
			$display("CHECK FAILED at %0t: edge source hung", $time);
			test_done();
		end else begin
			tick(6);
		end
	endtask : edges
	task wait_flag(input int idx);
		for (int i = 0; i < 400; i++) begin
			if (raw[idx] === 1'b1) return;
			tick(1);
		end
		miscompares++;
		$display("CHECK FAILED at %0t: flag %0d never rose", $time, idx);
		test_done();
	endtask : wait_flag
	// ==========================================================
	// Scenarios
	task reset_test;
		chk(tv, 16'hFFFF, "reset count");
		chk({5'h00, run, raw, mskd, irq, pwm}, 16'h0000, "reset state");
		$display("reset test done");
	endtask : reset_test
	// Load A, match 6, both edges: four edges end it, two more are ignored
	task count_test;
		setup(CFG_16BIT, TMR_CAPTURE, 1'b0, 1'b0, EVT_BOTH, 8'h05, 4'h2);
		load(16'h000A, 16'h0006);
		edges(8'h01);
		chk(tv, 16'h0009, "one edge, one step");
		edges(8'h03);
		chk({11'h000, run, raw}, 16'h0002, "match stops run");
		chk({11'h000, mskd, irq}, 16'h0005, "match masked");
		chk(tv, 16'h000A, "reloaded");
		edges(8'h02);
		chk({15'h0000, run}, 16'h0000, "still stopped");
		chk(tv, 16'h000A, "late edges ignored");
		clear_flags(4'h2);
		chk({12'h000, raw}, 16'h0000, "match cleared");
		$display("edge count test done");
	endtask : count_test
	// Period 6, rising edges 8 cycles apart: second capture is 2 counts lower
	task time_test;
		logic [15:0] c1;
		setup(CFG_16BIT, TMR_CAPTURE, 1'b1, 1'b0, EVT_RISE, 8'h05, 4'h0);
		load(16'h0005, 16'hFFFF);
		src_start(8'h04);
		wait_flag(FLG_EVENT);
		c1 = tv;
		chk({11'h000, mskd, irq}, 16'h0000, "event masked off");
		clear_flags(4'h4);
		tick(2);
		chk(tv, c1, "falling edge ignored");
		chk({12'h000, raw}, 16'h0000, "no flag on falling");
		wait_flag(FLG_EVENT);
		tick(1);
		chk(tv, (c1 + 16'h0004) % 16'h0006, "second capture");
		chk({15'h0000, run}, 16'h0001, "keeps running");
		// Sticky event flag must not leak into the PWM flag check
		clear_flags(4'h4);
		chk({12'h000, raw}, 16'h0000, "event cleared");
		$display("edge time test done");
	endtask : time_test
	// Load 9, match 2: high 7 of every 10 cycles, 3 when inverted
	task pwm_test;
		int          highs;
		int          bad;
		logic [15:0] prev;
		setup(CFG_16BIT, TMR_PERIODIC, 1'b0, 1'b1, EVT_RISE, 8'h05, 4'hF);
		load(16'h0009, 16'h0002);
		for (int v = 0; v < 2; v++) begin
			@(posedge clock_i) inv <= 1'(v);
			tick(12);
			highs = 0;
			bad = 0;
			prev = tv;
			repeat (20) begin
				tick(1);
				highs += int'(pwm === 1'b1);
				if (tv !== ((prev == 16'h0000) ? 16'h0009 : prev - 16'h0001)) bad++;
				prev = tv;
			end
			chk(16'(highs), v ? 16'h0006 : 16'h000E, "pwm high cycles");
			chk(16'(bad), 16'h0000, "pwm count steps");
		end
		// Clock enable low freezes the live count
		@(posedge clock_i) ce <= 1'b0;
		tick(2);
		prev = tv;
		tick(4);
		chk(tv, prev, "count frozen while clock enable low");
		@(posedge clock_i) ce <= 1'b1;
		#1;
		chk({10'h000, run, raw, irq}, 16'h0020, "pwm runs, no flags");
		$display("pwm test done");
	endtask : pwm_test
	task timer_test;
		for (int k = 0; k < 2; k++) begin
			setup(k ? CFG_16BIT : CFG_32BIT, k ? TMR_PERIODIC : TMR_ONE_SHOT, 1'b0, 1'b0,
				EVT_RISE, 8'h00, 4'h1);
			load(16'h0003, 16'hFFFF);
			wait_flag(FLG_TIMEOUT);
			tick(3);
			chk({14'h0000, run, irq}, k ? 16'h0003 : 16'h0001, "after time-out");
			if (k == 0) begin
				chk(tv, 16'h0003, "one-shot holds load");
				clear_flags(4'h1);
				chk({12'h000, raw}, 16'h0000, "time-out cleared");
			end
		end
		$display("timer test done");
	endtask : timer_test
	// RTC enable starts the count at one; a tick needs 32768 slow edges, too long here
	task rtc_test;
		setup(CFG_RTC, TMR_ONE_SHOT, 1'b0, 1'b0, EVT_RISE, 8'h00, 4'h8);
		clear_flags(4'hF);
		load(16'h0009, 16'h0003);
		chk(tv, 16'h0001, "rtc starts at one");
		edges(8'h02);
		chk(tv, 16'h0001, "rtc holds until a tick");
		chk({11'h000, run, raw}, 16'h0010, "rtc running, no flag");
		$display("rtc test done");
	endtask : rtc_test
	// ==========================================================
	// Main sequence
	initial begin
		tick(4);
		@(posedge clock_i) nrst_i <= 1'b1;
		@(posedge clock_i) ce <= 1'b1;
		tick(1);
		reset_test();
		count_test();
		time_test();
		pwm_test();
		timer_test();
		rtc_test();
		test_done();
	end
endmodule : gp_timer_capture_pwm_modes_tb_top
